// ---- common/ycc_pkg.sv ----
package ycc_pkg;

  // fixed-point format of all coefficients
  localparam int FRAC   = 12;
  localparam int ONE    = 1 << FRAC;
  localparam int PIX_W  = 8;
  localparam int OPD_W  = 10;
  localparam int COEF_W = 16;
  localparam int LATENCY = 1;

  localparam int OFS_LUMA_STUDIO = 16;
  localparam int OFS_CHROMA      = 128;
  localparam int PIX_MAX         = 255;

  typedef enum logic [2:0] {
    YCC_PASS    = 3'h0,
    YCC_BT601   = 3'h1,
    YCC_STUDIO  = 3'h2,
    YCC_SFULL   = 3'h3,
    YCC_REVERSE = 3'h4
  } ycc_mode_t;

  localparam real W601_R  = 0.299;
  localparam real W601_G  = 0.587;
  localparam real W601_B  = 0.114;
  localparam real K601_U  = 0.564;
  localparam real K601_V  = 0.713;
  localparam real WSRGB_R = 0.2126;
  localparam real WSRGB_G = 0.7152;
  localparam real WSRGB_B = 0.0722;
  localparam real KSRGB_U = 0.5389;
  localparam real KSRGB_V = 0.635;
  localparam real SCALE_Y = 219.0 / 256.0;
  localparam real SCALE_C = 224.0 / 256.0;
  localparam real REV_RV  = 1.5748;
  localparam real REV_GU  = 0.1873;
  localparam real REV_GV  = 0.4681;
  localparam real REV_BU  = 1.8556;

  // real to fixed point, rounded to nearest
  function automatic int q(input real x);
    return int'(x * real'(ONE));
  endfunction

  // rows: luma/R, U/G, V/B; columns: first, second, third operand
  localparam int K_PASS [9] = '{ONE, 0, 0, 0, ONE, 0, 0, 0, ONE};

  // chroma rows are forced to sum to zero so grey gives exactly the offset
  localparam int K_BT601 [9] = '{
    q(W601_R), q(W601_G), q(W601_B),
    -q(K601_U * W601_R), -q(K601_U * W601_G), q(K601_U * W601_R) + q(K601_U * W601_G),
    q(K601_V * W601_G) + q(K601_V * W601_B), -q(K601_V * W601_G), -q(K601_V * W601_B)};

  localparam int K_STUDIO [9] = '{
    q(WSRGB_R * SCALE_Y), q(WSRGB_G * SCALE_Y), q(WSRGB_B * SCALE_Y),
    -q(KSRGB_U * SCALE_C * WSRGB_R), -q(KSRGB_U * SCALE_C * WSRGB_G),
    q(KSRGB_U * SCALE_C * WSRGB_R) + q(KSRGB_U * SCALE_C * WSRGB_G),
    q(KSRGB_V * SCALE_C * WSRGB_G) + q(KSRGB_V * SCALE_C * WSRGB_B),
    -q(KSRGB_V * SCALE_C * WSRGB_G), -q(KSRGB_V * SCALE_C * WSRGB_B)};

  localparam int K_SFULL [9] = '{
    q(WSRGB_R), q(WSRGB_G), q(WSRGB_B),
    -q(KSRGB_U * WSRGB_R), -q(KSRGB_U * WSRGB_G), q(KSRGB_U * WSRGB_R) + q(KSRGB_U * WSRGB_G),
    q(KSRGB_V * WSRGB_G) + q(KSRGB_V * WSRGB_B), -q(KSRGB_V * WSRGB_G), -q(KSRGB_V * WSRGB_B)};

  // operands here are Y, U-128, V-128
  localparam int K_REVERSE [9] = '{
    ONE, 0, q(REV_RV),
    ONE, -q(REV_GU), -q(REV_GV),
    ONE, q(REV_BU), 0};

endpackage

// ---- rtl/ycc_dot3.sv ----
`timescale 1ns/1ps
module ycc_dot3 #(
  parameter int OPD_W  = ycc_pkg::OPD_W,
  parameter int COEF_W = ycc_pkg::COEF_W,
  parameter int FRAC   = ycc_pkg::FRAC
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // operands and coefficients
  input  wire logic signed [OPD_W-1:0]  a0,
  input  wire logic signed [OPD_W-1:0]  a1,
  input  wire logic signed [OPD_W-1:0]  a2,
  input  wire logic signed [COEF_W-1:0] k0,
  input  wire logic signed [COEF_W-1:0] k1,
  input  wire logic signed [COEF_W-1:0] k2,
  input  wire logic signed [OPD_W-1:0]  offset,
  input  wire logic                     sat_signed,
  // result
  output logic             [7:0]        res
);

  localparam int SUM_W = OPD_W + COEF_W + 2;

  if (OPD_W < 10 || COEF_W < 14 || FRAC < 8 || FRAC > COEF_W - 2) begin : g_chk
    $error("ycc_dot3: unsupported width");
  end

  logic signed [SUM_W-1:0] sum;
  logic signed [SUM_W-1:0] rounded;
  logic signed [SUM_W-1:0] whole;
  logic                    hi_sat;
  logic                    lo_sat;
  logic        [7:0]       next_res;

  assign sum = SUM_W'(a0 * k0) + SUM_W'(a1 * k1) + SUM_W'(a2 * k2)
             + (SUM_W'(offset) <<< FRAC);
  // add half an LSB then floor: nearest, ties upward
  assign rounded = sum + (SUM_W'(1) <<< (FRAC - 1));
  assign whole   = rounded >>> FRAC;
  assign hi_sat  = sat_signed ? (whole > SUM_W'(127)) : (whole > SUM_W'(255));
  assign lo_sat  = sat_signed ? (whole < -SUM_W'(128)) : (whole < SUM_W'(0));
  assign next_res = hi_sat ? (sat_signed ? 8'h7F : 8'hFF) :
                    lo_sat ? (sat_signed ? 8'h80 : 8'h00) : whole[7:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res <= 8'h00;
    end else begin
      res <= next_res;
    end
  end

endmodule

// ---- rtl/ycc_color_converter.sv ----
// Contract
// - pass stream unchanged or convert one format
// - components are 8-bit gamma outputs
// - BT601 outputs span 0 to 255
// - BT601 luma weights 0.299 0.587 0.114
// - BT601 U is 0.564(B-Y)+128
// - BT601 V is 0.713(R-Y)+128
// - BT601 option drops chroma offset, signed
// - studio luma sRGB weights, 219/256, plus 16
// - studio Cb 0.5389(B-Y)*224/256+128
// - studio Cr 0.635(R-Y)*224/256+128
// - sRGB full luma, no scaling or offset
// - sRGB full U is 0.5389(B-Y)+128
// - sRGB full V is 0.635(R-Y)+128
// - sRGB full option drops chroma offset
// - reverse transform YUV back to RGB
`timescale 1ns/1ps
module ycc_color_converter #(
  parameter int PIX_W = ycc_pkg::PIX_W
) (
  // clock and reset
  input  wire logic             CORE_CLK,
  input  wire logic             RST,
  // conversion control, sampled with each pixel
  input  wire logic [2:0]       MODE,
  input  wire logic             NO_OFFSET,
  // pixel in: R,G,B or Y,U,V
  input  wire logic             IN_VALID,
  input  wire logic [PIX_W-1:0] IN_C0,
  input  wire logic [PIX_W-1:0] IN_C1,
  input  wire logic [PIX_W-1:0] IN_C2,
  // pixel out
  output logic                  OUT_VALID,
  output logic                  OUT_SIGNED,
  output logic      [7:0]       OUT_C0,
  output logic      [7:0]       OUT_C1,
  output logic      [7:0]       OUT_C2
);

  localparam int OPD_W  = ycc_pkg::OPD_W;
  localparam int COEF_W = ycc_pkg::COEF_W;

  // the gamma stage delivers 8 bits; wider would not fit the operands
  if (PIX_W != 8) begin : g_chk
    $error("ycc_color_converter: pixel width must be 8");
  end

  function automatic logic signed [COEF_W-1:0] coef_of(input logic [2:0] m,
                                                       input int idx);
    logic signed [COEF_W-1:0] k;
    k = COEF_W'(ycc_pkg::K_PASS[idx]);
    case (m)
      ycc_pkg::YCC_BT601:   k = COEF_W'(ycc_pkg::K_BT601[idx]);
      ycc_pkg::YCC_STUDIO:  k = COEF_W'(ycc_pkg::K_STUDIO[idx]);
      ycc_pkg::YCC_SFULL:   k = COEF_W'(ycc_pkg::K_SFULL[idx]);
      ycc_pkg::YCC_REVERSE: k = COEF_W'(ycc_pkg::K_REVERSE[idx]);
      default:              k = COEF_W'(ycc_pkg::K_PASS[idx]);
    endcase
    return k;
  endfunction

  wire       is_601     = (MODE == ycc_pkg::YCC_BT601);
  wire       is_studio  = (MODE == ycc_pkg::YCC_STUDIO);
  wire       is_sfull   = (MODE == ycc_pkg::YCC_SFULL);
  wire       is_reverse = (MODE == ycc_pkg::YCC_REVERSE);
  // studio range has no offset-free variant
  wire       drop_ofs   = NO_OFFSET & (is_601 | is_sfull);
  wire       next_signed = IN_VALID ? drop_ofs : OUT_SIGNED;

  wire signed [OPD_W-1:0] opd0 = OPD_W'({2'b00, IN_C0});
  // reverse transform works on centred chroma
  wire signed [OPD_W-1:0] opd1 = is_reverse ?
    OPD_W'({2'b00, IN_C1}) - OPD_W'(ycc_pkg::OFS_CHROMA) : OPD_W'({2'b00, IN_C1});
  wire signed [OPD_W-1:0] opd2 = is_reverse ?
    OPD_W'({2'b00, IN_C2}) - OPD_W'(ycc_pkg::OFS_CHROMA) : OPD_W'({2'b00, IN_C2});

  wire signed [OPD_W-1:0] ofs_luma = is_studio ? OPD_W'(ycc_pkg::OFS_LUMA_STUDIO)
                                               : OPD_W'(0);
  wire signed [OPD_W-1:0] ofs_chroma =
    (is_601 | is_studio | is_sfull) & ~drop_ofs ? OPD_W'(ycc_pkg::OFS_CHROMA)
                                                : OPD_W'(0);

  // every mode runs through the same three dot products; pass uses identity
  ycc_dot3 u_row0 (
    .clk        (CORE_CLK),
    .rst        (RST),
    .a0         (opd0),
    .a1         (opd1),
    .a2         (opd2),
    .k0         (coef_of(MODE, 0)),
    .k1         (coef_of(MODE, 1)),
    .k2         (coef_of(MODE, 2)),
    .offset     (ofs_luma),
    .sat_signed (1'b0),
    .res        (OUT_C0)
  );

  ycc_dot3 u_row1 (
    .clk        (CORE_CLK),
    .rst        (RST),
    .a0         (opd0),
    .a1         (opd1),
    .a2         (opd2),
    .k0         (coef_of(MODE, 3)),
    .k1         (coef_of(MODE, 4)),
    .k2         (coef_of(MODE, 5)),
    .offset     (ofs_chroma),
    .sat_signed (drop_ofs),
    .res        (OUT_C1)
  );

  ycc_dot3 u_row2 (
    .clk        (CORE_CLK),
    .rst        (RST),
    .a0         (opd0),
    .a1         (opd1),
    .a2         (opd2),
    .k0         (coef_of(MODE, 6)),
    .k1         (coef_of(MODE, 7)),
    .k2         (coef_of(MODE, 8)),
    .offset     (ofs_chroma),
    .sat_signed (drop_ofs),
    .res        (OUT_C2)
  );

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      OUT_VALID  <= 1'b0;
      OUT_SIGNED <= 1'b0;
    end else begin
      OUT_VALID  <= IN_VALID;
      OUT_SIGNED <= next_signed;
    end
  end

  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  wire grey_in = IN_VALID && (IN_C0 == IN_C1) && (IN_C1 == IN_C2);

  valid_latency_a: assert property (
    IN_VALID |=> OUT_VALID)
    else $error("pixel not delivered one cycle later");

  pass_through_a: assert property (
    IN_VALID && MODE == ycc_pkg::YCC_PASS |=>
      OUT_C0 == $past(IN_C0) && OUT_C1 == $past(IN_C1) && OUT_C2 == $past(IN_C2))
    else $error("pass mode altered the pixel");

  bt601_grey_a: assert property (
    grey_in && is_601 && !NO_OFFSET |=>
      OUT_C0 == $past(IN_C0) && OUT_C1 == 8'h80 && OUT_C2 == 8'h80)
    else $error("bt601 grey not neutral");

  bt601_red_sat_a: assert property (
    IN_VALID && is_601 && !NO_OFFSET && IN_C0 == 8'hFF && IN_C1 == 8'h00 && IN_C2 == 8'h00
      |=> OUT_C0 == 8'h4C && OUT_C2 == 8'hFF)
    else $error("bt601 pure red wrong");

  bt601_full_white_a: assert property (
    grey_in && is_601 && IN_C0 == 8'hFF |=> OUT_C0 == 8'hFF)
    else $error("bt601 white luma not 255");

  no_offset_grey_a: assert property (
    grey_in && (is_601 || is_sfull) && NO_OFFSET |=>
      OUT_SIGNED && OUT_C1 == 8'h00 && OUT_C2 == 8'h00)
    else $error("offset-free chroma not zero for grey");

  studio_black_a: assert property (
    grey_in && is_studio && IN_C0 == 8'h00 |=>
      OUT_C0 == 8'h10 && OUT_C1 == 8'h80 && OUT_C2 == 8'h80 && !OUT_SIGNED)
    else $error("studio black not 16/128/128");

  studio_white_a: assert property (
    grey_in && is_studio && IN_C0 == 8'hFF |=> OUT_C0 == 8'hEA && OUT_C1 == 8'h80)
    else $error("studio white luma not 234");

  sfull_grey_a: assert property (
    grey_in && is_sfull && !NO_OFFSET |=>
      OUT_C0 == $past(IN_C0) && OUT_C1 == 8'h80 && OUT_C2 == 8'h80)
    else $error("srgb full grey not neutral");

  reverse_grey_a: assert property (
    IN_VALID && is_reverse && IN_C1 == 8'h80 && IN_C2 == 8'h80 |=>
      OUT_C0 == $past(IN_C0) && OUT_C1 == $past(IN_C0) && OUT_C2 == $past(IN_C0))
    else $error("reverse of neutral chroma not grey");

  reverse_sat_a: assert property (
    IN_VALID && is_reverse && IN_C0 == 8'hFF && IN_C1 == 8'hFF |=> OUT_C2 == 8'hFF)
    else $error("reverse blue did not saturate");

  // strobe falls in the cycle after a gap; flag may only move with a taken pixel
  valid_drop_a: assert property (
    !IN_VALID |=> !OUT_VALID)
    else $error("output strobe without a pixel");

  signed_set_a: assert property (
    IN_VALID && NO_OFFSET && (is_601 || is_sfull) |=> OUT_SIGNED)
    else $error("offset-free pixel not flagged signed");

  signed_clear_a: assert property (
    IN_VALID && !(NO_OFFSET && (is_601 || is_sfull)) |=> !OUT_SIGNED)
    else $error("offset pixel flagged signed");

  signed_hold_a: assert property (
    !IN_VALID |=> $stable(OUT_SIGNED))
    else $error("signed flag moved between pixels");

  bt601_blue_a: assert property (
    IN_VALID && is_601 && !NO_OFFSET && {IN_C0, IN_C1, IN_C2} == 24'h0000FF
      |=> OUT_C0 == 8'h1D && OUT_C1 == 8'hFF)
    else $error("bt601 pure blue wrong");

  bt601_signed_blue_a: assert property (
    IN_VALID && is_601 && NO_OFFSET && {IN_C0, IN_C1, IN_C2} == 24'h0000FF
      |=> OUT_C1 == 8'h7F)
    else $error("bt601 signed blue chroma wrong");

  sfull_blue_a: assert property (
    IN_VALID && is_sfull && !NO_OFFSET && {IN_C0, IN_C1, IN_C2} == 24'h0000FF
      |=> OUT_C0 == 8'h12 && OUT_C1 == 8'hFF)
    else $error("srgb full pure blue wrong");

  studio_no_ofs_a: assert property (
    grey_in && is_studio && NO_OFFSET |=>
      !OUT_SIGNED && OUT_C1 == 8'h80 && OUT_C2 == 8'h80)
    else $error("studio chroma lost its offset");

  reverse_red_a: assert property (
    IN_VALID && is_reverse && {IN_C0, IN_C1, IN_C2} == 24'h8080FF
      |=> OUT_C0 == 8'hFF && OUT_C1 == 8'h45 && OUT_C2 == 8'h80)
    else $error("reverse of strong V wrong");

  cov_bt601_c:   cover property (IN_VALID && is_601 ##1 OUT_VALID);
  cov_studio_c:  cover property (IN_VALID && is_studio ##1 OUT_VALID);
  cov_sfull_c:   cover property (IN_VALID && is_sfull ##1 OUT_VALID);
  cov_reverse_c: cover property (IN_VALID && is_reverse ##1 OUT_VALID);
  cov_signed_c:  cover property (IN_VALID && drop_ofs ##1 OUT_SIGNED);

endmodule

// ---- sim/ycc_gamma_src.sv ----
`timescale 1ns/1ps
// upstream gamma stage: one pixel per call, no back-pressure
module ycc_gamma_src (
  // clock
  input  wire logic       clk,
  // pixel stream toward the converter
  output logic            valid,
  output logic      [2:0] mode,
  output logic            no_offset,
  output logic      [7:0] c0,
  output logic      [7:0] c1,
  output logic      [7:0] c2
);
  initial begin
    valid = 1'b0;
    mode = 3'h0;
    no_offset = 1'b0;
    {c0, c1, c2} = 24'h5A5A5A;
  end

  task automatic put(input logic [2:0] m, input logic n, input logic [7:0] a, b, c);
    @(posedge clk);
    valid <= 1'b1;
    mode <= m;
    no_offset <= n;
    c0 <= a;
    c1 <= b;
    c2 <= c;
  endtask

  // gaps show the inverse so a stale pixel can never look valid
  task automatic idle();
    @(posedge clk);
    valid <= 1'b0;
    c0 <= ~c0;
    c1 <= ~c1;
    c2 <= ~c2;
  endtask
endmodule

// ---- sim/yuv_color_space_converter_tb_top.sv ----
`timescale 1ns/1ps
module yuv_color_space_converter_tb_top;
  typedef struct packed {
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
    logic       sg;
    logic       tol;
  } ycc_note_t;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  wire logic  in_valid;
  wire logic  no_off;
  wire logic [2:0] mode;
  wire logic [7:0] c0, c1, c2;
  logic       out_valid, out_signed;
  logic [7:0] o0, o1, o2;
  int         err_total = 0;
  int         checks_done = 0;
  int         seed = 32'h7885;
  ycc_note_t  notes[$];
  ycc_note_t  got;

  always #25 clk = ~clk;

  ycc_gamma_src src (.clk(clk), .valid(in_valid), .mode(mode), .no_offset(no_off),
                     .c0(c0), .c1(c1), .c2(c2));
  ycc_color_converter dut (.CORE_CLK(clk), .RST(rst), .MODE(mode), .NO_OFFSET(no_off),
    .IN_VALID(in_valid), .IN_C0(c0), .IN_C1(c1), .IN_C2(c2), .OUT_VALID(out_valid),
    .OUT_SIGNED(out_signed), .OUT_C0(o0), .OUT_C1(o1), .OUT_C2(o2));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // fixed-point results may differ from exact math by one code
  task automatic check(input string nm, input logic [7:0] seen, exp, input logic tol, sg);
    logic [8:0] s;
    logic [8:0] e;
    s = {1'b0, seen ^ {sg, 7'h0}};
    e = {1'b0, exp ^ {sg, 7'h0}};
    checks_done++;
    if (!(s === e || (tol === 1'b1 && (s === e + 9'h1 || s + 9'h1 === e)))) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [7:0] sat(input real x, input logic sg);
    real r;
    r = $floor(x + 0.5);
    if (sg) r = r > 127.0 ? 127.0 : (r < -128.0 ? -128.0 : r);
    else r = r > 255.0 ? 255.0 : (r < 0.0 ? 0.0 : r);
    return 8'(int'(r));
  endfunction

  task automatic send(input logic [2:0] m, input logic n, input logic [7:0] a, b, c);
    real r, g, bl, y, u, v, ofs;
    ycc_note_t e;
    r = a;
    g = b;
    bl = c;
    e.sg = n && (m == 3'h1 || m == 3'h3);
    ofs = e.sg ? 0.0 : 128.0;
    e.tol = 1'b1;
    case (m)
      3'h1: begin
        y = 0.299 * r + 0.587 * g + 0.114 * bl;
        u = 0.564 * (bl - y) + ofs;
        v = 0.713 * (r - y) + ofs;
      end
      3'h2: begin
        y = 0.2126 * r + 0.7152 * g + 0.0722 * bl;
        u = 0.5389 * (bl - y) * 224.0 / 256.0 + 128.0;
        v = 0.635 * (r - y) * 224.0 / 256.0 + 128.0;
        y = y * 219.0 / 256.0 + 16.0;
      end
      3'h3: begin
        y = 0.2126 * r + 0.7152 * g + 0.0722 * bl;
        u = 0.5389 * (bl - y) + ofs;
        v = 0.635 * (r - y) + ofs;
      end
      3'h4: begin
        y = r + 1.5748 * (bl - 128.0);
        u = r - 0.1873 * (g - 128.0) - 0.4681 * (bl - 128.0);
        v = r + 1.8556 * (g - 128.0);
      end
      default: begin
        y = r;
        u = g;
        v = bl;
        e.tol = 1'b0;
      end
    endcase
    e.c0 = sat(y, 1'b0);
    e.c1 = sat(u, e.sg);
    e.c2 = sat(v, e.sg);
    notes.push_back(e);
    src.put(m, n, a, b, c);
  endtask

  always @(negedge clk) begin
    if (out_valid === 1'b1) begin
      check("pending", 8'(notes.size() > 0), 8'h01, 1'b0, 1'b0);
      got = notes.size() > 0 ? notes.pop_front() : '0;
      check("out_c0", o0, got.c0, got.tol, 1'b0);
      check("out_c1", o1, got.c1, got.tol, got.sg);
      check("out_c2", o2, got.c2, got.tol, got.sg);
      check("out_signed", {7'h0, out_signed}, {7'h0, got.sg}, 1'b0, 1'b0);
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int m = 0; m < 8; m++) begin
      for (int n = 0; n < 2; n++) begin
        send(3'(m), n[0], 8'hFF, 8'h00, 8'h00);
        send(3'(m), n[0], 8'h00, 8'h00, 8'hFF);
        send(3'(m), n[0], 8'hFF, 8'hFF, 8'hFF);
        send(3'(m), n[0], 8'h00, 8'hFF, 8'h00);
        send(3'(m), n[0], 8'h00, 8'h00, 8'h00);
        send(3'(m), n[0], 8'h40, 8'h80, 8'h80);
        send(3'(m), n[0], 8'h80, 8'h80, 8'hFF);
        src.idle();
      end
    end
    repeat (300) begin
      send(3'($random(seed)), 1'($random(seed)), 8'($random(seed)), 8'($random(seed)),
           8'($random(seed)));
      if ($random(seed) & 1) src.idle();
    end
    src.idle();
    @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    check("rst_out", o0 | o1 | o2 | {6'h0, out_valid, out_signed}, 8'h00, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    send(3'h1, 1'b1, 8'h00, 8'hFF, 8'h00);
    src.idle();
    repeat (3) @(posedge clk);
    check("left", 8'(notes.size()), 8'h00, 1'b0, 1'b0);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("CHECK FAILED watchdog expected done seen hang");
    print_verdict();
  end
endmodule
